// [src/dprs_pkg.sv]
// Shared constants and types for the DPLL reference selection and state control
package dprs_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] REG_CAUSE_MASKS_ADDR = 8'h34;
  localparam logic [7:0] REG_FINE_MASKS_ADDR  = 8'hF4;
  localparam int         SW_MASK_LSB          = 0;
  localparam int         HO_MASK_LSB          = 4;
  localparam int         FINE_SW_BIT          = 0;
  localparam int         FINE_HO_BIT          = 1;
  localparam logic [3:0] SWITCH_MASK_RST      = 4'h8;
  localparam logic [3:0] HOLDOVER_MASK_RST    = 4'h7;
  localparam logic       FINE_SW_MASK_RST     = 1'b0;
  localparam logic       FINE_HO_MASK_RST     = 1'b1;

  // ****************************************
  // Reference selection
  // ****************************************
  localparam int         NUM_REFS      = 4;
  localparam int         PRIO_W        = 3;
  localparam logic [2:0] PRIO_EXCLUDED = 3'h7;
  localparam logic [1:0] REF_RST       = 2'h0;

  // ****************************************
  // DPLL state command and status codes
  // ****************************************
  localparam logic [1:0] CMD_NORMAL   = 2'h0;
  localparam logic [1:0] CMD_HOLDOVER = 2'h1;
  localparam logic [1:0] CMD_FREERUN  = 2'h2;

  typedef enum logic [1:0] {
    ST_FREERUN,
    ST_NORMAL,
    ST_HOLDOVER
  } dprs_state_t;

  // Bits [3:0] line up with the four-bit mask fields
  typedef struct packed {
    logic fine_freq_check;
    logic guard_soak_timer;
    logic rough_freq_check;
    logic single_period_check;
    logic signal_loss_flag;
  } dprs_cause_t;

  typedef struct packed {
    logic       managed;
    logic [1:0] state_cmd;
    logic [1:0] ref_sel_cmd;
    logic       manual_switch;
    logic       hitless;
    logic [1:0] default_ref;
  } dprs_host_ctrl_t;

endpackage : dprs_pkg

// [src/dprs_best_ref.sv]
// Priority picker: best available reference by priority, ties to lower index
`timescale 1ns/1ps
module dprs_best_ref #(
  parameter int N      = 4,
  parameter int PRIO_W = 3
) (
  input  wire logic [N-1:0]             avail_i,
  input  wire logic [N-1:0][PRIO_W-1:0] prio_i,
  output logic                          found_o,
  output logic [$clog2(N)-1:0]          idx_o
);

  // ****************************************
  // Search
  // ****************************************
  // Walk downward with <= so the lowest index wins a tie
  always_comb begin
    found_o = 1'b0;
    idx_o   = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (avail_i[i] && (!found_o || prio_i[i] <= prio_i[idx_o])) begin // R17
        found_o = 1'b1;
        idx_o   = ($clog2(N))'(i);
      end
    end
  end

endmodule : dprs_best_ref

// [src/dprs_ctrl.sv]
// DPLL state control and input reference selection, one per DPLL
`timescale 1ns/1ps

// Overview of operation
// (R1) Two control modes: automatic un-managed and host-driven managed.
// (R2) Un-managed: own state machine picks DPLL state and reference.
// (R3) Managed: host bits set DPLL state and reference; device follows.
// (R4) Leaving managed mode keeps the locked reference until conditions change.
// (R5) State, selection, style, monitor, holdover and lock bits reach GPIO.
// (R6) Each DPLL has its own independent instance of this logic.
// (R7) Pick highest-priority available reference; fall back down the list.
// (R8) Switch only on causes whose switch mask bit is one.
// (R9) Switch mask resets to 1000; fine switch mask to 0.
// (R10) Enter holdover on causes whose holdover mask bit is one.
// (R11) Enter holdover when switching is needed but nothing else available.
// (R12) Holdover mask resets to 0111; fine holdover mask to 1.
// (R13) Leave holdover once no holdover condition remains.
// (R14) All references failed: holdover and keep current selection.
// (R15) Reference in use is always readable on status bits.
// (R16) Auto/manual switching, switching style and default reference configurable.
// (R17) Three-bit priority, lower wins, 111 excludes, ties to lower index.
// (R18) Non-revertive among equals; revert to a strictly higher priority.
// (R19) Used reference encoded 00..11 for references 0..3.
// (R20) Managed reference change passes through holdover, then normal.
module dprs_ctrl
  import dprs_pkg::*;
#(
  parameter int N_REFS = NUM_REFS
) (
  input  wire logic                          clock_i,
  input  wire logic                          rstn_i,
  input  wire logic [7:0]                    reg_addr_i,
  input  wire logic                          reg_wr_i,
  input  wire logic                          reg_rd_i,
  input  wire logic [7:0]                    reg_wdata_i,
  output logic      [7:0]                    reg_rdata_o,
  input  wire dprs_cause_t [N_REFS-1:0]      cause_i,
  input  wire logic [N_REFS-1:0][PRIO_W-1:0] prio_i,
  input  wire dprs_host_ctrl_t               host_i,
  input  wire logic                          lock_ind_i,
  output logic      [1:0]                    dpll_state_o,
  output logic                               normal_o,
  output logic                               holdover_o,
  output logic      [1:0]                    used_ref_o,
  output logic      [2:0]                    ref_mon_o,
  output logic                               lock_o,
  output logic                               hitless_o
);

  localparam int IDX_W = $clog2(N_REFS);

  // ****************************************
  // Cause decoding
  // ****************************************
  function automatic logic cause_hit(input dprs_cause_t c, input logic [3:0] m4,
                                     input logic mf);
    cause_hit = (|(c[3:0] & m4)) | (c.fine_freq_check & mf);
  endfunction : cause_hit

  // ****************************************
  // Mask registers
  // ****************************************
  logic [3:0] sw_mask_q;
  logic [3:0] ho_mask_q;
  logic       fine_sw_q;
  logic       fine_ho_q;

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sw_mask_q <= SWITCH_MASK_RST;   // R9
      ho_mask_q <= HOLDOVER_MASK_RST; // R12
    end else if (reg_wr_i && reg_addr_i == REG_CAUSE_MASKS_ADDR) begin
      sw_mask_q <= reg_wdata_i[SW_MASK_LSB +: 4];
      ho_mask_q <= reg_wdata_i[HO_MASK_LSB +: 4];
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      fine_sw_q <= FINE_SW_MASK_RST; // R9
      fine_ho_q <= FINE_HO_MASK_RST; // R12
    end else if (reg_wr_i && reg_addr_i == REG_FINE_MASKS_ADDR) begin
      fine_sw_q <= reg_wdata_i[FINE_SW_BIT];
      fine_ho_q <= reg_wdata_i[FINE_HO_BIT];
    end
  end

  // Unmapped reads return zero
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        REG_CAUSE_MASKS_ADDR: reg_rdata_o <= {ho_mask_q, sw_mask_q};
        REG_FINE_MASKS_ADDR:  reg_rdata_o <= {6'h00, fine_ho_q, fine_sw_q};
        default:              reg_rdata_o <= 8'h00;
      endcase
    end
  end

  // ****************************************
  // Per-reference qualification
  // ****************************************
  logic [N_REFS-1:0] sw_hit;
  logic [N_REFS-1:0] ho_hit;
  logic [N_REFS-1:0] clean;
  logic [N_REFS-1:0] avail;
  logic [N_REFS-1:0] alt_avail;
  logic [IDX_W-1:0]  cur_q;
  logic [IDX_W-1:0]  ref_d;

  for (genvar g = 0; g < N_REFS; g++) begin : g_qual
    assign sw_hit[g]    = cause_hit(cause_i[g], sw_mask_q, fine_sw_q); // R8
    assign ho_hit[g]    = cause_hit(cause_i[g], ho_mask_q, fine_ho_q); // R10
    assign clean[g]     = !sw_hit[g] && !ho_hit[g];
    assign avail[g]     = clean[g] && prio_i[g] != PRIO_EXCLUDED;     // R17
    assign alt_avail[g] = avail[g] && cur_q != IDX_W'(g);
  end

  logic             best_found;
  logic [IDX_W-1:0] best_idx;
  logic             alt_found;
  logic [IDX_W-1:0] alt_idx;

  dprs_best_ref #(
    .N      (N_REFS),
    .PRIO_W (PRIO_W)
  ) u_best (
    .avail_i (avail),
    .prio_i  (prio_i),
    .found_o (best_found),
    .idx_o   (best_idx)
  );

  // Same picker with the current reference removed: the switch target
  dprs_best_ref #(
    .N      (N_REFS),
    .PRIO_W (PRIO_W)
  ) u_alt (
    .avail_i (alt_avail),
    .prio_i  (prio_i),
    .found_o (alt_found),
    .idx_o   (alt_idx)
  );

  // ****************************************
  // State machine
  // ****************************************
  dprs_state_t state_q;
  dprs_state_t state_d;
  logic        start_q;
  logic        need_switch;
  logic        auto_sw;

  // Excluded current reference counts as a switch condition
  assign need_switch = sw_hit[cur_q] || prio_i[cur_q] == PRIO_EXCLUDED;
  assign auto_sw     = !host_i.manual_switch; // R16

  always_comb begin
    state_d = state_q;
    ref_d   = cur_q;
    if (host_i.managed) begin // R1
      case (host_i.state_cmd) // R3
        CMD_FREERUN:  state_d = ST_FREERUN;
        CMD_HOLDOVER: state_d = ST_HOLDOVER;
        default: begin
          ref_d = host_i.ref_sel_cmd[IDX_W-1:0];
          // Change of target holds one cycle in holdover before locking
          if (ref_d != cur_q || !clean[ref_d]) begin // R20
            state_d = ST_HOLDOVER;
          end else begin
            state_d = ST_NORMAL;
          end
        end
      endcase
    end else begin // R2
      case (state_q)
        ST_FREERUN: begin
          if (avail[cur_q]) begin
            state_d = ST_NORMAL;
          end else if (auto_sw && best_found) begin // R7
            ref_d   = best_idx;
            state_d = ST_NORMAL;
          end
        end
        ST_NORMAL: begin
          if (ho_hit[cur_q]) begin
            state_d = ST_HOLDOVER; // R10 R14
          end else if (need_switch) begin
            if (auto_sw && alt_found) begin
              ref_d = alt_idx; // R7 R8
            end else begin
              state_d = ST_HOLDOVER; // R11 R14
            end
          end else if (auto_sw && best_found && prio_i[best_idx] < prio_i[cur_q]) begin
            ref_d = best_idx; // R18
          end
        end
        ST_HOLDOVER: begin
          if (clean[cur_q] && prio_i[cur_q] != PRIO_EXCLUDED) begin
            state_d = ST_NORMAL; // R13 R4
          end else if (!ho_hit[cur_q] && auto_sw && alt_found) begin
            ref_d   = alt_idx; // R11
            state_d = ST_NORMAL;
          end
        end
        default: state_d = ST_FREERUN;
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_q <= ST_FREERUN;
    end else begin
      state_q <= state_d; // R6
    end
  end

  // Default reference is caught on the first edge after reset release
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      start_q <= 1'b1;
      cur_q   <= REF_RST;
    end else begin
      start_q <= 1'b0;
      if (start_q) begin
        cur_q <= host_i.default_ref[IDX_W-1:0]; // R16
      end else begin
        cur_q <= ref_d; // R4 R14
      end
    end
  end

  // ****************************************
  // Status outputs, all GPIO-routable
  // ****************************************
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      dpll_state_o <= CMD_FREERUN;
      normal_o     <= 1'b0;
      holdover_o   <= 1'b0;
      ref_mon_o    <= 3'h0;
      lock_o       <= 1'b0;
      hitless_o    <= 1'b0;
    end else begin
      case (state_d) // R5
        ST_NORMAL:   dpll_state_o <= CMD_NORMAL;
        ST_HOLDOVER: dpll_state_o <= CMD_HOLDOVER;
        default:     dpll_state_o <= CMD_FREERUN;
      endcase
      normal_o   <= state_d == ST_NORMAL;
      holdover_o <= state_d == ST_HOLDOVER;
      ref_mon_o  <= cause_i[cur_q][2:0]; // R5
      lock_o     <= lock_ind_i && state_d == ST_NORMAL;
      hitless_o  <= host_i.hitless; // R16
    end
  end

  // Follows cur_q directly with no extra edge, as cur_q itself is the registered choice
  assign used_ref_o = 2'(cur_q); // R15 R19

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);

  logic run_q;
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      run_q <= 1'b0;
    end else begin
      run_q <= 1'b1;
    end
  end

  sequence s_sel_change;
    run_q && host_i.managed && host_i.state_cmd == CMD_NORMAL
      && host_i.ref_sel_cmd[IDX_W-1:0] != cur_q;
  endsequence

  sequence s_pass_holdover;
    holdover_o && used_ref_o == $past(host_i.ref_sel_cmd);
  endsequence

  a_mask_reset_val: assert property (!run_q |-> sw_mask_q == 4'h8 && ho_mask_q == 4'h7 // R9
    && !fine_sw_q && fine_ho_q)
    else $error("cause masks not at reset values");

  a_managed_freerun: assert property (run_q && host_i.managed // R3
    && host_i.state_cmd == CMD_FREERUN |=> dpll_state_o == CMD_FREERUN && !normal_o)
    else $error("managed freerun command not followed");

  a_managed_ref_change: assert property (s_sel_change |=> s_pass_holdover) // R20
    else $error("managed reference change did not pass through holdover");

  a_holdover_entry: assert property (run_q && !host_i.managed && state_q == ST_NORMAL // R10
    && ho_hit[cur_q] |=> holdover_o && cur_q == $past(cur_q))
    else $error("holdover cause did not enter holdover");

  a_no_alt_holdover: assert property (run_q && !host_i.managed && state_q == ST_NORMAL // R11
    && need_switch && !alt_found |=> holdover_o)
    else $error("switch need without alternative did not enter holdover");

  a_switch_to_best: assert property (run_q && !host_i.managed && auto_sw // R7
    && state_q == ST_NORMAL && !ho_hit[cur_q] && need_switch && alt_found
    |=> cur_q == $past(alt_idx) && normal_o)
    else $error("failed reference not replaced by best alternative");

  a_holdover_exit: assert property (run_q && !host_i.managed && state_q == ST_HOLDOVER // R13
    && avail[cur_q] |=> normal_o)
    else $error("holdover not left when conditions cleared");

  a_keep_ref_all_fail: assert property (run_q && !host_i.managed && avail == '0 // R14
    |=> $stable(cur_q))
    else $error("reference switched with no reference available");

  a_no_equal_revert: assert property (run_q && !host_i.managed && state_q == ST_NORMAL // R18
    && clean[cur_q] && prio_i[cur_q] != PRIO_EXCLUDED && prio_i[best_idx] == prio_i[cur_q]
    |=> $stable(cur_q))
    else $error("reverted between equal priority references");

  a_managed_holdover: assert property (run_q && host_i.managed // R3
    && host_i.state_cmd == CMD_HOLDOVER |=> holdover_o && $stable(cur_q))
    else $error("managed holdover command not followed");

  a_revert_higher: assert property (run_q && !host_i.managed && auto_sw // R18
    && state_q == ST_NORMAL && !ho_hit[cur_q] && !need_switch && best_found
    && prio_i[best_idx] < prio_i[cur_q] |=> cur_q == $past(best_idx) && normal_o)
    else $error("higher priority reference not taken back");

  a_manual_keeps_ref: assert property (run_q && !host_i.managed // R16
    && host_i.manual_switch |=> $stable(cur_q))
    else $error("reference changed under manual switching");

  a_hitless_copy: assert property (run_q |=> hitless_o == $past(host_i.hitless)) // R16
    else $error("switching style not passed to its status bit");

  a_lock_needs_normal: assert property (lock_o |-> normal_o && $past(lock_ind_i)) // R5
    else $error("lock status shown outside normal state");

endmodule : dprs_ctrl

// [tb/dprs_host_model.sv]
// Host processor model: register cycles and control bits for the selector
`timescale 1ns/1ps
module dprs_host_model
  import dprs_pkg::*;
(
  input  wire logic       clock_i,
  input  wire logic [7:0] reg_rdata_i,
  output logic      [7:0] reg_addr_o,
  output logic            reg_wr_o,
  output logic            reg_rd_o,
  output logic      [7:0] reg_wdata_o,
  output dprs_host_ctrl_t host_o
);
  initial begin
    reg_addr_o  = 8'h00;
    reg_wr_o    = 1'b0;
    reg_rd_o    = 1'b0;
    reg_wdata_o = 8'h00;
    host_o      = '0;
  end

  // ****************************************
  // Register cycles, one strobe cycle each
  // ****************************************
  // Address and data flip once released, so stale values never look valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    reg_addr_o  <= a;
    reg_wdata_o <= d;
    reg_wr_o    <= 1'b1;
    @(posedge clock_i);
    reg_wr_o    <= 1'b0;
    reg_addr_o  <= ~a;
    reg_wdata_o <= ~d;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock_i);
    reg_addr_o <= a;
    reg_rd_o   <= 1'b1;
    @(posedge clock_i);
    reg_rd_o   <= 1'b0;
    reg_addr_o <= ~a;
    #1;
    d = reg_rdata_i;
  endtask : rd

  // ****************************************
  // Mode, state and reference commands
  // ****************************************
  task automatic set_ctrl(input dprs_host_ctrl_t c);
    @(posedge clock_i);
    host_o <= c;
  endtask : set_ctrl
endmodule : dprs_host_model

// [tb/dprs_ctrl_test.sv]
// Self-checking testbench for the DPLL state control and reference selection
`timescale 1ns/1ps
module dprs_ctrl_test;
  import dprs_pkg::*;
  logic              clock_i;
  logic              rstn_i;
  logic              lock_ind;
  logic [7:0]        reg_addr, reg_wdata, reg_rdata, rd_val;
  logic              reg_wr, reg_rd;
  dprs_cause_t [3:0] cause;
  logic [3:0][2:0]   prio;
  dprs_host_ctrl_t   host_c, hc;
  logic [1:0]        dpll_state, used_ref;
  logic              normal, holdover, lock, hitless;
  logic [2:0]        ref_mon;
  int                error_cnt;
  int                compares;

  dprs_host_model host (.clock_i(clock_i), .reg_rdata_i(reg_rdata), .reg_addr_o(reg_addr),
    .reg_wr_o(reg_wr), .reg_rd_o(reg_rd), .reg_wdata_o(reg_wdata), .host_o(host_c));

  dprs_ctrl dut (.clock_i(clock_i), .rstn_i(rstn_i), .reg_addr_i(reg_addr),
    .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_wdata_i(reg_wdata), .reg_rdata_o(reg_rdata),
    .cause_i(cause), .prio_i(prio), .host_i(host_c), .lock_ind_i(lock_ind),
    .dpll_state_o(dpll_state), .normal_o(normal), .holdover_o(holdover),
    .used_ref_o(used_ref), .ref_mon_o(ref_mon), .lock_o(lock), .hitless_o(hitless));

  always #25 clock_i = ~clock_i;

  // ****************************************
  // Checking helpers
  // ****************************************
  task automatic conclude();
    $display("Mismatches %0d, comparisons %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : conclude

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  // Transitions may pass through holdover, so poll with a bound
  task automatic expect_state(input logic [1:0] r, input logic n, input logic h);
    int i;
    for (i = 0; i < 12; i++) begin
      @(posedge clock_i);
      #1;
      if (used_ref === r && normal === n && holdover === h) break;
    end
    compares++;
    if (i == 12) begin
      error_cnt++;
      $display("BAD %0t ref %0d normal %b holdover %b", $time, used_ref, normal, holdover);
      conclude();
    end
  endtask : expect_state

  task automatic set_cause(input int r, input logic [4:0] v);
    @(posedge clock_i);
    cause[r] <= v;
  endtask : set_cause

  task automatic clear_causes();
    @(posedge clock_i);
    cause <= '0;
  endtask : clear_causes

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    clock_i   = 1'b0;
    rstn_i    = 1'b0;
    lock_ind  = 1'b1;
    cause     = '0;
    prio      = {3'h3, 3'h2, 3'h1, 3'h0};
    error_cnt = 0;
    compares  = 0;
    hc        = '0;
    repeat (16) @(posedge clock_i);
    rstn_i <= 1'b1;
    hc.hitless = 1'b1;
    host.set_ctrl(hc);
    host.rd(REG_CAUSE_MASKS_ADDR, rd_val);
    check(rd_val, 8'h78);
    host.rd(REG_FINE_MASKS_ADDR, rd_val);
    check(rd_val, 8'h02);
    host.rd(8'h55, rd_val);
    check(rd_val, 8'h00);
    expect_state(2'h0, 1'b1, 1'b0);
    check({7'h00, lock}, 8'h01);
    check({7'h00, hitless}, 8'h01);
    @(posedge clock_i);
    lock_ind <= 1'b0;
    expect_state(2'h0, 1'b1, 1'b0);
    check({7'h00, lock}, 8'h00);
    @(posedge clock_i);
    lock_ind <= 1'b1;
    // Default masks: loss holds over, guard soak switches
    set_cause(0, 5'h01);
    expect_state(2'h0, 1'b0, 1'b1);
    check({5'h00, ref_mon}, 8'h01);
    check({6'h00, dpll_state}, 8'h01);
    check({7'h00, lock}, 8'h00);
    clear_causes();
    expect_state(2'h0, 1'b1, 1'b0);
    set_cause(0, 5'h08);
    expect_state(2'h1, 1'b1, 1'b0);
    clear_causes();
    expect_state(2'h0, 1'b1, 1'b0);
    // Loss switches only, walk down the list to exhaustion
    host.wr(REG_CAUSE_MASKS_ADDR, 8'h01);
    host.rd(REG_CAUSE_MASKS_ADDR, rd_val);
    check(rd_val, 8'h01);
    set_cause(0, 5'h01);
    expect_state(2'h1, 1'b1, 1'b0);
    set_cause(1, 5'h01);
    expect_state(2'h2, 1'b1, 1'b0);
    set_cause(2, 5'h01);
    expect_state(2'h3, 1'b1, 1'b0);
    set_cause(3, 5'h01);
    expect_state(2'h3, 1'b0, 1'b1);
    clear_causes();
    expect_state(2'h0, 1'b1, 1'b0);
    // Fine frequency cause, switch then holdover
    host.wr(REG_FINE_MASKS_ADDR, 8'h01);
    set_cause(0, 5'h10);
    expect_state(2'h1, 1'b1, 1'b0);
    clear_causes();
    expect_state(2'h0, 1'b1, 1'b0);
    host.wr(REG_FINE_MASKS_ADDR, 8'h02);
    set_cause(0, 5'h10);
    expect_state(2'h0, 1'b0, 1'b1);
    clear_causes();
    expect_state(2'h0, 1'b1, 1'b0);
    // Excluded reference and manual switching
    @(posedge clock_i);
    prio[0] <= PRIO_EXCLUDED;
    expect_state(2'h1, 1'b1, 1'b0);
    @(posedge clock_i);
    prio[0] <= 3'h0;
    expect_state(2'h0, 1'b1, 1'b0);
    hc.manual_switch = 1'b1;
    host.set_ctrl(hc);
    set_cause(0, 5'h01);
    expect_state(2'h0, 1'b0, 1'b1);
    clear_causes();
    expect_state(2'h0, 1'b1, 1'b0);
    hc.manual_switch = 1'b0;
    // Managed mode with equal priorities, then hand back
    @(posedge clock_i);
    prio <= '0;
    hc.managed     = 1'b1;
    hc.state_cmd   = CMD_NORMAL;
    hc.ref_sel_cmd = 2'h2;
    host.set_ctrl(hc);
    expect_state(2'h2, 1'b0, 1'b1);
    expect_state(2'h2, 1'b1, 1'b0);
    hc.state_cmd = CMD_FREERUN;
    host.set_ctrl(hc);
    expect_state(2'h2, 1'b0, 1'b0);
    check({6'h00, dpll_state}, 8'h02);
    hc.state_cmd = CMD_HOLDOVER;
    host.set_ctrl(hc);
    expect_state(2'h2, 1'b0, 1'b1);
    check({6'h00, dpll_state}, 8'h01);
    hc.state_cmd = CMD_NORMAL;
    host.set_ctrl(hc);
    expect_state(2'h2, 1'b1, 1'b0);
    hc.managed = 1'b0;
    host.set_ctrl(hc);
    repeat (4) @(posedge clock_i);
    #1;
    check({6'h00, used_ref}, 8'h02);
    set_cause(2, 5'h01);
    expect_state(2'h0, 1'b1, 1'b0);
    // Second reset: default reference is caught again after release
    hc = '0;
    hc.manual_switch = 1'b1;
    hc.default_ref   = 2'h1;
    host.set_ctrl(hc);
    clear_causes();
    rstn_i <= 1'b0;
    repeat (16) @(posedge clock_i);
    #1;
    check({4'h0, dpll_state, used_ref}, 8'h08);
    @(posedge clock_i);
    rstn_i <= 1'b1;
    expect_state(2'h1, 1'b1, 1'b0);
    host.rd(REG_CAUSE_MASKS_ADDR, rd_val);
    check(rd_val, 8'h78);
    check({6'h00, used_ref}, 8'h01);
    conclude();
  end
endmodule : dprs_ctrl_test
